// ==== hw/pin_mux_pkg.sv ====
/*
  Constants, register map and types for the pin output source select block.
  Assumes a single 40 MHz system clock and an AXI4-Lite register master.
*/
package pin_mux_pkg;

  localparam int NUM_OUT = 7;
  localparam int NUM_IN = 16;
  localparam int NUM_PIN_IN = 32;
  localparam int CODE_W = 5;
  localparam int ADDR_W = 8;

  localparam logic [7:0] OFS_LOCK = 8'h00;
  localparam logic [7:0] OFS_IN_BASE = 8'h40;
  localparam logic [7:0] OFS_OUT_BASE = 8'h80;

  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
  localparam int LOCK_BIT = 0;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  localparam logic [4:0] CODE_LATCH = 5'h00;
  localparam logic [4:0] CODE_CMP1 = 5'h16;
  localparam logic [4:0] CODE_PWM3 = 5'h0e;
  localparam logic [1:0] CODE_RSV_HI = 2'b11;
  localparam logic [4:0] OUT_SEL_RST = 5'h00;

  // one bit per source code: routable to the port A pins of this block
  localparam logic [31:0] PORTA_AVAIL = 32'h00c00039;
  // one bit per source code: peripheral owns the pin direction
  localparam logic [31:0] DIR_OVERRIDE = 32'h00330f00;

  // per peripheral input: bit n set when port n (A=0..D=3) may feed it
  localparam logic [3:0] IN_PORT_AVAIL [NUM_IN] = '{
    4'h3, 4'h3, 4'h5, 4'h6, 4'h6, 4'h6, 4'he, 4'h6,
    4'h6, 4'hd, 4'h6, 4'h6, 4'h5, 4'h5, 4'he, 4'he};

  // power-on selection of each peripheral input: pin 0 of first legal port
  localparam logic [4:0] IN_SEL_RST [NUM_IN] = '{
    5'h00, 5'h00, 5'h00, 5'h08, 5'h08, 5'h08, 5'h08, 5'h08,
    5'h08, 5'h00, 5'h08, 5'h08, 5'h00, 5'h00, 5'h08, 5'h08};

  typedef enum logic [1:0] {
    LK_IDLE = 2'b00,
    LK_KEY1 = 2'b01,
    LK_ARMED = 2'b11
  } lock_seq_t;

  typedef enum logic [1:0] {
    RK_NONE = 2'b00,
    RK_LOCK = 2'b01,
    RK_IN = 2'b11,
    RK_OUT = 2'b10
  } reg_kind_t;

  typedef struct packed {
    reg_kind_t kind;
    logic [3:0] idx;
  } reg_sel_t;

  typedef struct packed {
    logic [NUM_OUT-1:0] value;
    logic [NUM_OUT-1:0] oe;
  } pin_drive_t;

endpackage

// ==== hw/pin_output_source_select.sv ====
/*
  Pin output source select with peripheral input select and selection lock.
  Assumes an AXI4-Lite master on sys_clk, pin inputs from outside the clock
  domain, and peripheral signals and pin latches from logic on sys_clk.
*/
// Functional notes
// - each output pin has a 32-bit register, low five bits pick its source
// - lower codes pick latch, oscillator, logic cells, complementary, capture, pwm
// - upper codes pick serial clock/data, usart, comparator outputs
// - reserved source codes drive logic zero onto the pin
// - each source reaches only its listed ports; latch reaches every port
// - complementary, serial and usart sources take over the pin direction
// - while locked, writes to every selection register are ignored
// - while unlocked, selection register writes update normally
// - selections clear on power-on or brown-out only; lock clears on any reset
// - unimplemented upper bits read zero and ignore writes
// - one 5-bit input select register per routable peripheral input
// - with one-shot config the lock, once set, stays set until reset
// - input code: bits 4:3 port, 2:0 pin; unsupported ports feed zero
`timescale 1ns/10ps
`default_nettype none

module pin_output_source_select (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic porReset,
  input wire logic oneShotLockConfig,
  input wire logic awvalid,
  output logic awready,
  input wire logic [pin_mux_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [pin_mux_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic [pin_mux_pkg::NUM_OUT-1:0] pinLatch,
  input wire logic [pin_mux_pkg::NUM_OUT-1:0] pinDirControl,
  input wire logic [31:0] periphOut,
  input wire logic [31:0] periphDirOut,
  input wire logic [pin_mux_pkg::NUM_PIN_IN-1:0] pinIn,
  output pin_mux_pkg::pin_drive_t pinDrive,
  output logic [pin_mux_pkg::NUM_IN-1:0] periphIn
);

  function automatic pin_mux_pkg::reg_sel_t decodeAddr(input logic [7:0] a);
    pin_mux_pkg::reg_sel_t s;
    s.kind = pin_mux_pkg::RK_NONE;
    s.idx = a[5:2];
    if (a == pin_mux_pkg::OFS_LOCK) begin
      s.kind = pin_mux_pkg::RK_LOCK;
    end else if (a[1:0] == 2'b00 && a[7:6] == pin_mux_pkg::OFS_IN_BASE[7:6]) begin
      s.kind = pin_mux_pkg::RK_IN;
    end else if (a[1:0] == 2'b00 && a[7:6] == pin_mux_pkg::OFS_OUT_BASE[7:6]
                 && a[5:2] < 4'(pin_mux_pkg::NUM_OUT)) begin
      s.kind = pin_mux_pkg::RK_OUT;
    end
    return s;
  endfunction

  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic awPend_q, wPend_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic wStrb0_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic lock_q;
  pin_mux_pkg::lock_seq_t lockSeq_q;
  logic [4:0] outSel_q [pin_mux_pkg::NUM_OUT];
  logic [4:0] inSel_q [pin_mux_pkg::NUM_IN];
  logic [31:0] pinS1_q, pinS2_q, pinS3_q, pinFilt_q;
  pin_mux_pkg::pin_drive_t pinDrive_q;
  logic [pin_mux_pkg::NUM_IN-1:0] periphIn_q;

  pin_mux_pkg::reg_sel_t wrSel, rdSel;
  logic doWrite, wrEn, selWrEn;

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign pinDrive = pinDrive_q;
  assign periphIn = periphIn_q;

  assign wrSel = decodeAddr(awAddr_q);
  assign rdSel = decodeAddr(araddr);
  // address and data may land in either order; commit once both are held
  assign doWrite = awPend_q && wPend_q && !bvalid_q;
  assign wrEn = clkEn && doWrite && wStrb0_q;
  assign selWrEn = wrEn && !lock_q;

  // write channel
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      awPend_q <= 1'b0;
      wPend_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= pin_mux_pkg::RESP_OKAY;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb0_q <= 1'b0;
    end else if (clkEn) begin
      if (awvalid && awready_q) begin
        awPend_q <= 1'b1;
        awready_q <= 1'b0;
        awAddr_q <= awaddr;
      end
      if (wvalid && wready_q) begin
        wPend_q <= 1'b1;
        wready_q <= 1'b0;
        wData_q <= wdata;
        wStrb0_q <= wstrb[0];
      end
      if (doWrite) begin
        bvalid_q <= 1'b1;
        bresp_q <= (wrSel.kind == pin_mux_pkg::RK_NONE) ?
                   pin_mux_pkg::RESP_DECERR : pin_mux_pkg::RESP_OKAY;
      end
      if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
        awPend_q <= 1'b0;
        wPend_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // read channel
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= pin_mux_pkg::RESP_OKAY;
    end else if (clkEn) begin
      if (arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rresp_q <= pin_mux_pkg::RESP_OKAY;
        rdata_q <= '0;
        case (rdSel.kind)
          pin_mux_pkg::RK_LOCK: rdata_q[pin_mux_pkg::LOCK_BIT] <= lock_q;
          pin_mux_pkg::RK_IN: rdata_q[4:0] <= inSel_q[rdSel.idx];
          pin_mux_pkg::RK_OUT: rdata_q[4:0] <= outSel_q[rdSel.idx[2:0]];
          default: rresp_q <= pin_mux_pkg::RESP_DECERR;
        endcase
      end else if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // lock bit and its unlock sequence; every reset clears the lock
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      lock_q <= 1'b0;
      lockSeq_q <= pin_mux_pkg::LK_IDLE;
    end else if (wrEn) begin
      if (wrSel.kind == pin_mux_pkg::RK_LOCK) begin
        case (lockSeq_q)
          pin_mux_pkg::LK_IDLE: begin
            if (wData_q[7:0] == pin_mux_pkg::UNLOCK_KEY1) begin
              lockSeq_q <= pin_mux_pkg::LK_KEY1;
            end
          end
          pin_mux_pkg::LK_KEY1: begin
            if (wData_q[7:0] == pin_mux_pkg::UNLOCK_KEY2) begin
              lockSeq_q <= pin_mux_pkg::LK_ARMED;
            end else if (wData_q[7:0] != pin_mux_pkg::UNLOCK_KEY1) begin
              lockSeq_q <= pin_mux_pkg::LK_IDLE;
            end
          end
          pin_mux_pkg::LK_ARMED: begin
            // a one-shot lock cannot be released once it has been set
            if (!(oneShotLockConfig && lock_q)) begin
              lock_q <= wData_q[pin_mux_pkg::LOCK_BIT];
            end
            lockSeq_q <= pin_mux_pkg::LK_IDLE;
          end
          default: lockSeq_q <= pin_mux_pkg::LK_IDLE;
        endcase
      end else begin
        // any write to another register breaks the sequence
        lockSeq_q <= pin_mux_pkg::LK_IDLE;
      end
    end
  end

  // selection registers survive every reset except power-on or brown-out
  always_ff @(posedge sys_clk) begin
    if (sys_rst && porReset) begin
      for (int i = 0; i < pin_mux_pkg::NUM_OUT; i++) begin
        outSel_q[i] <= pin_mux_pkg::OUT_SEL_RST;
      end
      for (int j = 0; j < pin_mux_pkg::NUM_IN; j++) begin
        inSel_q[j] <= pin_mux_pkg::IN_SEL_RST[j];
      end
    end else if (!sys_rst && selWrEn) begin
      if (wrSel.kind == pin_mux_pkg::RK_OUT) begin
        outSel_q[wrSel.idx[2:0]] <= wData_q[4:0];
      end
      if (wrSel.kind == pin_mux_pkg::RK_IN) begin
        inSel_q[wrSel.idx] <= wData_q[4:0];
      end
    end
  end

  // pin inputs: three stages, a change is taken once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pinS1_q <= '0;
      pinS2_q <= '0;
      pinS3_q <= '0;
      pinFilt_q <= '0;
    end else if (clkEn) begin
      pinS1_q <= pinIn;
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      for (int k = 0; k < pin_mux_pkg::NUM_PIN_IN; k++) begin
        if (pinS2_q[k] == pinS3_q[k]) begin
          pinFilt_q[k] <= pinS3_q[k];
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < pin_mux_pkg::NUM_OUT; g++) begin : g_out
      logic [4:0] code;
      logic avail;
      assign code = outSel_q[g];
      // reserved and off-port codes have no availability bit, so drive zero
      assign avail = pin_mux_pkg::PORTA_AVAIL[code];
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          pinDrive_q.value[g] <= 1'b0;
          pinDrive_q.oe[g] <= 1'b0;
        end else if (clkEn) begin
          if (code == pin_mux_pkg::CODE_LATCH) begin
            pinDrive_q.value[g] <= pinLatch[g];
          end else begin
            pinDrive_q.value[g] <= avail && periphOut[code];
          end
          if (avail && pin_mux_pkg::DIR_OVERRIDE[code]) begin
            pinDrive_q.oe[g] <= periphDirOut[code];
          end else begin
            pinDrive_q.oe[g] <= !pinDirControl[g];
          end
        end
      end
    end

    for (g = 0; g < pin_mux_pkg::NUM_IN; g++) begin : g_in
      logic [4:0] sel;
      assign sel = inSel_q[g];
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          periphIn_q[g] <= 1'b0;
        end else if (clkEn) begin
          // an unsupported port feeds zero rather than a stray pin
          periphIn_q[g] <= pin_mux_pkg::IN_PORT_AVAIL[g][sel[4:3]]
                           && pinFilt_q[sel];
        end
      end
    end
  endgenerate

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_reserved_zero;
    clkEn && outSel_q[0][4:3] == pin_mux_pkg::CODE_RSV_HI |=> !pinDrive_q.value[0];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved code drove a one");

  property p_offport_zero;
    clkEn && outSel_q[0] == pin_mux_pkg::CODE_PWM3 |=> !pinDrive_q.value[0];
  endproperty
  a_offport_zero: assert property (p_offport_zero)
    else $error("source not routable to port drove the pin");

  property p_latch_pass;
    clkEn && outSel_q[0] == pin_mux_pkg::CODE_LATCH
      |=> pinDrive_q.value[0] == $past(pinLatch[0]);
  endproperty
  a_latch_pass: assert property (p_latch_pass)
    else $error("latch value not on pin");

  property p_cmp1_pass;
    clkEn && outSel_q[0] == pin_mux_pkg::CODE_CMP1
      |=> pinDrive_q.value[0] == $past(periphOut[pin_mux_pkg::CODE_CMP1]);
  endproperty
  a_cmp1_pass: assert property (p_cmp1_pass)
    else $error("comparator output not on pin");

  property p_dir_pin_direction_control;
    clkEn && outSel_q[0] == pin_mux_pkg::CODE_LATCH
      |=> pinDrive_q.oe[0] == !$past(pinDirControl[0]);
  endproperty
  a_dir_pin_direction_control: assert property (p_dir_pin_direction_control)
    else $error("pin direction not from direction control");

  property p_locked_hold;
    lock_q && doWrite
      |=> $stable(outSel_q[0]) && $stable(inSel_q[0]) && $stable(inSel_q[3]);
  endproperty
  a_locked_hold: assert property (p_locked_hold)
    else $error("selection changed while locked");

  property p_unlocked_write;
    selWrEn && wrSel.kind == pin_mux_pkg::RK_OUT && wrSel.idx == 4'h0
      |=> outSel_q[0] == $past(wData_q[4:0]);
  endproperty
  a_unlocked_write: assert property (p_unlocked_write)
    else $error("unlocked write not stored");

  property p_warm_reset_keeps;
    @(posedge sys_clk) disable iff (1'b0)
    sys_rst && !porReset |=> $stable(outSel_q[0]) && !lock_q;
  endproperty
  a_warm_reset_keeps: assert property (p_warm_reset_keeps)
    else $error("warm reset disturbed selection or kept lock");

  property p_upper_zero;
    rvalid_q |-> rdata_q[31:5] == 27'h0000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("unimplemented bits read nonzero");

  property p_one_shot;
    oneShotLockConfig && lock_q |=> lock_q;
  endproperty
  a_one_shot: assert property (p_one_shot)
    else $error("one-shot lock released");

  property p_bad_port;
    clkEn && !pin_mux_pkg::IN_PORT_AVAIL[0][inSel_q[0][4:3]] |=> !periphIn_q[0];
  endproperty
  a_bad_port: assert property (p_bad_port)
    else $error("unsupported port fed a one");

  property p_in_write;
    selWrEn && wrSel.kind == pin_mux_pkg::RK_IN && wrSel.idx == 4'h0
      |=> inSel_q[0] == $past(wData_q[4:0]);
  endproperty
  a_in_write: assert property (p_in_write)
    else $error("unlocked input select write not stored");

  property p_read_back;
    clkEn && arvalid && arready_q && rdSel.kind == pin_mux_pkg::RK_OUT
      && rdSel.idx == 4'h0 |=> rdata_q[4:0] == $past(outSel_q[0]);
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("read did not return the held source code");

  // the lock may only move on the write that follows both keys
  property p_lock_needs_key;
    lockSeq_q != pin_mux_pkg::LK_ARMED |=> $stable(lock_q);
  endproperty
  a_lock_needs_key: assert property (p_lock_needs_key)
    else $error("lock bit changed without the key sequence");

endmodule
`default_nettype wire

// ==== verification/pin_world_model.sv ====
/*
  Far-side model: pin latches, direction control, peripheral outputs, pad levels.
  Assumes the bench sets pad levels through padSet; one sys_clk domain.
*/
`timescale 1ns/10ps
`default_nettype none
module pin_world_model (
  input wire logic [31:0] padSet,
  output logic [6:0] pinLatch,
  output logic [6:0] pinDirControl,
  output logic [31:0] periphOut,
  output logic [31:0] periphDirOut,
  output logic [31:0] pinIn
);
  // pin 0 latch low so that a routed source shows apart from the latch
  assign pinLatch = 7'h54;
  // pin 1 tristated: its direction control must still rule the driver
  assign pinDirControl = 7'h02;
  assign periphOut = 32'hffffffff;
  // every peripheral asks for the driver, yet none of them may act on port A
  assign periphDirOut = 32'hffffffff;
  // pads are asynchronous to sys_clk, the block synchronises them itself
  assign pinIn = padSet;
endmodule
`default_nettype wire

// ==== verification/pin_output_source_select_tb_top.sv ====
/*
  Self-checking bench: AXI4-Lite register tasks, source sweep, lock and resets.
  Assumes the design package and the far-side model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module pin_output_source_select_tb_top;
  localparam logic [7:0] LOCK = pin_mux_pkg::OFS_LOCK;
  localparam logic [7:0] IN0 = pin_mux_pkg::OFS_IN_BASE;
  localparam logic [7:0] OUT0 = pin_mux_pkg::OFS_OUT_BASE;
  // codes routable to port A: latch, oscillator, logic cells 1-2, comparators
  localparam logic [31:0] AVAIL_A = 32'h00c00039;
  logic sys_clk, sys_rst, porReset, oneShotLockConfig;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, periphOut, periphDirOut, pinIn, padSet, d;
  logic [1:0] bresp, rresp, r;
  logic [6:0] pinLatch, pinDirControl;
  logic [15:0] periphIn;
  pin_mux_pkg::pin_drive_t pinDrive;
  int numErrors, checked, cycles, c;

  pin_output_source_select pin_output_source_select_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(1'b1), .porReset(porReset),
    .oneShotLockConfig(oneShotLockConfig), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .pinLatch(pinLatch), .pinDirControl(pinDirControl),
    .periphOut(periphOut), .periphDirOut(periphDirOut), .pinIn(pinIn),
    .pinDrive(pinDrive), .periphIn(periphIn));

  pin_world_model pin_world_model_inst (
    .padSet(padSet), .pinLatch(pinLatch), .pinDirControl(pinDirControl),
    .periphOut(periphOut), .periphDirOut(periphDirOut), .pinIn(pinIn));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      numErrors++;
    end
  endtask

  task automatic testDone();
    if (numErrors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      numErrors++;
      testDone();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic lockSeq(input logic v);
    wr(LOCK, 32'h55);
    wr(LOCK, 32'haa);
    wr(LOCK, {31'h0, v});
  endtask

  task automatic doReset(input logic por);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    porReset <= por;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    porReset <= 1'b0;
  endtask

  initial begin
    sys_rst = 1'b1;
    porReset = 1'b1;
    oneShotLockConfig = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    padSet = '0;
    numErrors = 0;
    checked = 0;
    cycles = 0;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    porReset <= 1'b0;
    rd(LOCK); check(d, 32'h0);
    rd(OUT0); check(d, 32'h0);
    rd(IN0 + 8'h0c); check(d, 32'h8);
    wr(OUT0, 32'hffffffff); rd(OUT0); check(d, 32'h1f);
    wr(LOCK, 32'hff); rd(LOCK); check(d, 32'h0);
    rd(8'h20); check({30'h0, r}, 32'h3);
    wr(8'h9c, 32'h1); check({30'h0, r}, 32'h3);
    // sweep every source code on pin 0; pin 1 stays tristated throughout
    for (c = 0; c < 32; c++) begin
      wr(OUT0, c);
      repeat (3) @(posedge sys_clk);
      check({18'h0, pinDrive}, {18'h0, 7'h54 | {6'h0, c != 0 && AVAIL_A[c]}, 7'h7d});
    end
    wr(IN0, 32'h0a);
    padSet <= 32'h00000400;
    repeat (8) @(posedge sys_clk);
    check({31'h0, periphIn[0]}, 32'h1);
    padSet <= 32'h0;
    repeat (8) @(posedge sys_clk);
    check({31'h0, periphIn[0]}, 32'h0);
    wr(IN0, 32'h12);
    padSet <= 32'h00040000;
    repeat (8) @(posedge sys_clk);
    check({31'h0, periphIn[0]}, 32'h0);
    rd(IN0); check(d, 32'h12);
    lockSeq(1'b1); rd(LOCK); check(d, 32'h1);
    wr(OUT0, 32'h5); rd(OUT0); check(d, 32'h1f);
    wr(IN0 + 8'h0c, 32'h0b); rd(IN0 + 8'h0c); check(d, 32'h8);
    wr(LOCK, 32'h0); rd(LOCK); check(d, 32'h1);
    lockSeq(1'b0); rd(LOCK); check(d, 32'h0);
    wr(OUT0, 32'h5); rd(OUT0); check(d, 32'h5);
    // a write elsewhere between the keys must abort the sequence
    wr(LOCK, 32'h55);
    wr(OUT0 + 8'h04, 32'h3);
    wr(LOCK, 32'haa);
    wr(LOCK, 32'h1); rd(LOCK); check(d, 32'h0);
    lockSeq(1'b1);
    doReset(1'b0);
    rd(LOCK); check(d, 32'h0);
    rd(OUT0); check(d, 32'h5);
    doReset(1'b1);
    rd(OUT0); check(d, 32'h0);
    oneShotLockConfig <= 1'b1;
    lockSeq(1'b0);
    lockSeq(1'b1);
    lockSeq(1'b0); rd(LOCK); check(d, 32'h1);
    wr(OUT0, 32'h3); rd(OUT0); check(d, 32'h0);
    testDone();
  end
endmodule
`default_nettype wire
